// [tb_top.sv]
// Self-checking bench for the infrared pulse codec
`timescale 1ns/1ps
module tb_top;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic resetPinN = 1'b1;
    logic enablePin = 1'b1;
    logic modePin = 1'b1;
    logic [2:0] baud_select_pins = 3'h7;
    logic uartIn, uartOut, irIn, irOut, running, irPrev;
    logic [9:0] divisorNow;
    logic [7:0] echo;
    int errors = 0;
    int check_count = 0;
    int pulses = 0;
    always #4 clk_sys = ~clk_sys;
    uic_codec #(.RESET_DELAY_CYCLES(8)) uut (.clk_sys, .sys_rst, .resetPinN, .enablePin, .modePin, .baud_select_pins,
        .uartIn, .uartOut, .ir_pulse_in(irIn), .ir_pulse_out(irOut), .running, .divisorNow);
    uic_host_model host (.clk_sys, .rxLine(uartOut), .txLine(uartIn), .irLine(irIn));
    always @(posedge clk_sys) begin
        irPrev <= irOut;
        if (irOut === 1'b1 && irPrev === 1'b0) pulses <= pulses + 1;
    end
    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : check
    task automatic waitRun();
        for (int i = 0; i < 40 && running !== 1'b1; i++) @(posedge clk_sys);
        #1;
    endtask : waitRun
    task automatic t_reset();
        check(running === 1'b0 && uartOut === 1'b1 && irOut === 1'b0, "idle in delay");
        waitRun();
        check(running === 1'b1 && divisorNow === 10'h300, "soft start rate");
        resetPinN = 1'b0;
        repeat (6) @(posedge clk_sys);
        #1 check(running === 1'b0, "reset pin holds");
        resetPinN = 1'b1;
        repeat (8) @(posedge clk_sys);
        #1 check(running === 1'b0, "delay timer");
        waitRun();
        check(running === 1'b1, "run after delay");
        $display("t_reset done");
    endtask : t_reset
    task automatic t_encode();
        int base;
        base = pulses;
        host.uartXfer(8'h5a, echo);
        repeat (16) @(posedge clk_sys);
        check(pulses - base == 5, "zero bit pulses");
        $display("t_encode done");
    endtask : t_encode
    task automatic t_decode();
        logic [7:0] got;
        fork
            host.irSend(8'ha5);
            begin
                for (int i = 0; i < 2000 && uartOut !== 1'b0; i++) @(posedge clk_sys);
                repeat (host.div / 2) @(posedge clk_sys);
                for (int i = 0; i < 8; i++) begin
                    repeat (host.div) @(posedge clk_sys);
                    #1 got[i] = uartOut;
                end
            end
        join
        check(got === 8'ha5, "decoded byte");
        $display("t_decode done");
    endtask : t_decode
    task automatic t_baud();
        logic [7:0] codes [5] = '{8'h8b, 8'h85, 8'h83, 8'h81, 8'h87};
        logic [9:0] divs [5] = '{10'h180, 10'h0c0, 10'h080, 10'h040, 10'h300};
        logic [9:0] prev = 10'h300;
        modePin = 1'b0;
        repeat (8) @(posedge clk_sys);
        for (int k = 0; k < 5; k++) begin
            host.uartXfer(codes[k], echo);
            check(echo === codes[k], "code echo");
            host.uartXfer(8'h11, echo);
            check(echo === 8'h11 && divisorNow === prev, "rate held to stop");
            repeat (8) @(posedge clk_sys);
            #1 check(divisorNow === divs[k], "new rate");
            prev = divs[k];
            host.div = divs[k];
        end
        modePin = 1'b1;
        repeat (8) @(posedge clk_sys);
        $display("t_baud done");
    endtask : t_baud
    task automatic t_wake();
        enablePin = 1'b0;
        repeat (6) @(posedge clk_sys);
        #1 check(running === 1'b0 && irOut === 1'b0 && uartOut === 1'b1, "off state");
        enablePin = 1'b1;
        repeat (990) @(posedge clk_sys);
        #1 check(running === 1'b0, "wake delay");
        waitRun();
        check(running === 1'b1, "awake");
        $display("t_wake done");
    endtask : t_wake
    task automatic t_pins();
        logic [9:0] exp [5] = '{10'h300, 10'h180, 10'h0c0, 10'h080, 10'h040};
        for (int s = 0; s < 5; s++) begin
            baud_select_pins = 3'(s);
            repeat (8) @(posedge clk_sys);
            #1 check(divisorNow === exp[s], "pin rate");
        end
        $display("t_pins done");
    endtask : t_pins
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    initial begin
        repeat (4) @(posedge clk_sys);
        #1 sys_rst = 1'b0;
        t_reset();
        t_encode();
        t_decode();
        t_baud();
        t_wake();
        t_pins();
        summarize();
    end
    initial begin
        repeat (80000) @(posedge clk_sys);
        errors++;
        summarize();
    end
endmodule : tb_top

// [uic_codec.sv]
// Infrared pulse codec: UART to pulse encoder, pulse to UART decoder, baud control
`timescale 1ns/1ps
module uic_codec #(
    parameter int RESET_DELAY_CYCLES = 1024
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic resetPinN,
    input wire logic enablePin,
    input wire logic modePin,
    input wire logic [2:0] baud_select_pins,
    input wire logic uartIn,
    output logic uartOut,
    input wire logic ir_pulse_in,
    output logic ir_pulse_out,
    output logic running,
    output logic [9:0] divisorNow
);
    initial begin
        if (RESET_DELAY_CYCLES < 1) $error("uic_codec: reset delay must be positive");
    end

    // Two-stage synchronisers for every pin
    localparam int NS = 8;
    logic [NS-1:0] pinMeta_r;
    logic [NS-1:0] pinSync_r;
    always_ff @(posedge clk_sys) begin
        pinMeta_r <= {resetPinN, enablePin, modePin, baud_select_pins, uartIn, ir_pulse_in};
        pinSync_r <= pinMeta_r;
    end
    uic_pkg::uic_ctrl_t ctrl;
    assign ctrl = '{enable: pinSync_r[6], cmdMode: !pinSync_r[5], baudSel: pinSync_r[4:2]};
    wire rstPinN = pinSync_r[7];
    wire txLine = pinSync_r[1];
    wire irLine = pinSync_r[0];

    // Power and reset sequencing
    uic_pkg::uic_state_t state_r;
    logic [31:0] delay_r;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_r <= uic_pkg::UIC_ST_RESET;
            delay_r <= '0;
        end else if (!rstPinN) begin
            state_r <= uic_pkg::UIC_ST_RESET;
            delay_r <= '0;
        end else begin
            unique case (state_r)
                uic_pkg::UIC_ST_RESET: begin
                    delay_r <= delay_r + 1;
                    if (delay_r == 32'(RESET_DELAY_CYCLES - 1)) state_r <= uic_pkg::UIC_ST_RUN;
                end
                uic_pkg::UIC_ST_RUN: begin
                    delay_r <= '0;
                    if (!ctrl.enable) state_r <= uic_pkg::UIC_ST_OFF;
                end
                uic_pkg::UIC_ST_OFF: begin
                    delay_r <= '0;
                    if (ctrl.enable) state_r <= uic_pkg::UIC_ST_WAKE;
                end
                uic_pkg::UIC_ST_WAKE: begin
                    delay_r <= delay_r + 1;
                    if (!ctrl.enable) state_r <= uic_pkg::UIC_ST_OFF;
                    else if (delay_r == 32'(uic_pkg::WAKE_CYCLES) - 1) state_r <= uic_pkg::UIC_ST_RUN;
                end
            endcase
        end
    end
    wire live = state_r == uic_pkg::UIC_ST_RUN;

    // Baud divisor selection
    function automatic logic [9:0] hwDiv(input logic [2:0] sel);
        unique case (sel)
            3'h0: hwDiv = uic_pkg::DIV_768;
            3'h1: hwDiv = uic_pkg::DIV_384;
            3'h2: hwDiv = uic_pkg::DIV_192;
            3'h3: hwDiv = uic_pkg::DIV_128;
            3'h4: hwDiv = uic_pkg::DIV_64;
            default: hwDiv = uic_pkg::DIV_768;
        endcase
    endfunction
    function automatic logic [10:0] codeDiv(input logic [7:0] code);
        unique case (code)
            uic_pkg::CODE_768: codeDiv = {1'b1, uic_pkg::DIV_768};
            uic_pkg::CODE_384: codeDiv = {1'b1, uic_pkg::DIV_384};
            uic_pkg::CODE_192: codeDiv = {1'b1, uic_pkg::DIV_192};
            uic_pkg::CODE_128: codeDiv = {1'b1, uic_pkg::DIV_128};
            uic_pkg::CODE_64: codeDiv = {1'b1, uic_pkg::DIV_64};
            default: codeDiv = 11'h000; // Reserved codes ignored
        endcase
    endfunction
    wire softSel = ctrl.baudSel == uic_pkg::BAUD_SOFT_SEL;
    logic [9:0] softDiv_r;
    logic [9:0] lastCode_r;
    logic pendApply_r;
    wire [9:0] divisor = softSel ? softDiv_r : hwDiv(ctrl.baudSel);

    // Sub-bit clock prescaler, restarted on each start edge
    wire [5:0] subDiv = divisor[9:4];
    logic [5:0] preCnt_r;
    logic restart;
    wire subTick = preCnt_r == subDiv - 6'h01;
    always_ff @(posedge clk_sys) begin
        if (sys_rst || restart) preCnt_r <= '0;
        else if (subTick) preCnt_r <= '0;
        else preCnt_r <= preCnt_r + 6'h01;
    end

    // Shared framer: one frame at a time, half duplex
    logic busy_r;
    logic fromIr_r;
    logic [3:0] sub_r;
    logic [3:0] bitIdx_r;
    logic curBit_r;
    logic irSeenLow_r;
    logic [7:0] shift_r;
    logic txPrev_r;
    logic irPrev_r;
    always_ff @(posedge clk_sys) begin
        txPrev_r <= txLine;
        irPrev_r <= irLine;
    end
    wire txFall = txPrev_r && !txLine;
    wire irFall = irPrev_r && !irLine;
    wire bitEnd = busy_r && subTick && sub_r == uic_pkg::SUB_LAST;
    wire rxFrameDone = bitEnd && fromIr_r && bitIdx_r == uic_pkg::FRAME_BITS - 4'h1;
    wire txFrameDone = bitEnd && !fromIr_r && bitIdx_r == uic_pkg::FRAME_BITS - 4'h1;
    // A start edge from the same source on a frame's last tick is kept, so back-to-back bytes are not lost
    wire startTx = live && (!busy_r || txFrameDone) && txFall;
    wire startIr = live && (!busy_r || rxFrameDone) && !ctrl.cmdMode && !txFall && irFall;
    assign restart = startTx || startIr;
    logic byteDone;
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !live) begin
            busy_r <= 1'b0;
            fromIr_r <= 1'b0;
            sub_r <= '0;
            bitIdx_r <= '0;
            curBit_r <= 1'b1;
            irSeenLow_r <= 1'b0;
            shift_r <= '0;
        end else if (restart) begin
            busy_r <= 1'b1;
            fromIr_r <= startIr;
            sub_r <= '0;
            bitIdx_r <= '0;
            curBit_r <= 1'b0;
            irSeenLow_r <= startIr;
        end else if (busy_r && subTick) begin
            sub_r <= sub_r + 4'h1;
            if (fromIr_r && !irLine) irSeenLow_r <= 1'b1;
            // Host level taken one tick before the pulse slot, so the slot sees it whole
            if (!fromIr_r && sub_r == uic_pkg::SUB_MID - 4'h1 && bitIdx_r != 4'h0) curBit_r <= txLine;
            if (sub_r == uic_pkg::SUB_LAST) begin
                bitIdx_r <= bitIdx_r + 4'h1;
                irSeenLow_r <= 1'b0;
                if (fromIr_r) begin
                    // Last tick skipped: it may already see the next bit's pulse
                    curBit_r <= !irSeenLow_r;
                    if (rxFrameDone) busy_r <= 1'b0; // Frame ends after the stop bit's last tick
                end else begin
                    if (bitIdx_r >= 4'h1 && bitIdx_r <= 4'h8) shift_r <= {curBit_r, shift_r[7:1]};
                    if (txFrameDone) busy_r <= 1'b0;
                    curBit_r <= 1'b1;
                end
            end
        end
    end
    assign byteDone = txFrameDone && ctrl.cmdMode;

    // Command bytes queued for decoding; drained at one byte a cycle
    logic fifoValid;
    logic [7:0] fifoData;
    uic_fifo #(.WIDTH(uic_pkg::FIFO_WIDTH), .DEPTH(uic_pkg::FIFO_DEPTH)) cmdQueue (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .inValid(byteDone),
        .inReady(),
        .inData(shift_r),
        .outValid(fifoValid),
        .outReady(1'b1),
        .outData(fifoData)
    );
    logic [10:0] decoded;
    assign decoded = codeDiv(fifoData);
    always_ff @(posedge clk_sys) begin
        if (sys_rst || state_r == uic_pkg::UIC_ST_RESET) begin
            softDiv_r <= uic_pkg::DIV_768;
            lastCode_r <= uic_pkg::DIV_768;
            pendApply_r <= 1'b0;
        end else begin
            if (fifoValid && decoded[10]) lastCode_r <= decoded[9:0];
            // Echo stop already ended when the byte was queued
            if (pendApply_r && !busy_r) begin
                softDiv_r <= lastCode_r;
                pendApply_r <= 1'b0;
            end
            // A new change command wins over the clear
            if (fifoValid && fifoData == uic_pkg::CMD_CHANGE) pendApply_r <= 1'b1;
        end
    end

    // Output pins, registered
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !live) begin
            uartOut <= 1'b1;
            ir_pulse_out <= 1'b0;
        end else if (ctrl.cmdMode) begin
            uartOut <= txLine;
            ir_pulse_out <= 1'b0;
        end else begin
            // One bit of lag: a bit is known only once its time has ended
            uartOut <= (busy_r && fromIr_r && bitIdx_r != 4'h0) ? curBit_r : 1'b1;
            ir_pulse_out <= busy_r && !fromIr_r && !curBit_r && sub_r >= uic_pkg::TX_PULSE_START
                && sub_r < uic_pkg::TX_PULSE_END;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            running <= 1'b0;
            divisorNow <= uic_pkg::DIV_768;
        end else begin
            running <= live;
            divisorNow <= divisor;
        end
    end
endmodule : uic_codec

// [uic_codec_asserts.sv]
// Port checker for the infrared pulse codec
`timescale 1ns/1ps
module uic_codec_asserts (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic resetPinN,
    input wire logic enablePin,
    input wire logic modePin,
    input wire logic [2:0] baud_select_pins,
    input wire logic uartIn,
    input wire logic uartOut,
    input wire logic ir_pulse_in,
    input wire logic ir_pulse_out,
    input wire logic running,
    input wire logic [9:0] divisorNow
);
    logic [15:0] hiCnt_r;
    logic [15:0] holdCnt_r;
    logic [15:0] enCnt_r;
    logic lastOut_r;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    always_ff @(posedge clk_sys) begin
        hiCnt_r <= ir_pulse_out ? hiCnt_r + 16'h1 : 16'h0;
    end
    // Saturate so long idle spans never wrap into a false short bit
    always_ff @(posedge clk_sys) begin
        lastOut_r <= uartOut;
        if (sys_rst || (&holdCnt_r)) holdCnt_r <= 16'hffff;
        else holdCnt_r <= (uartOut != lastOut_r) ? 16'h1 : holdCnt_r + 16'h1;
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) enCnt_r <= 16'hffff;
        else if (!enablePin) enCnt_r <= 16'h0;
        else if (!(&enCnt_r)) enCnt_r <= enCnt_r + 16'h1;
    end
    a_idle_levels: assert property ((!running) [*2] |-> !ir_pulse_out && uartOut) else $error("idle levels");
    a_pulse_len: assert property ($fell(ir_pulse_out) && running |-> hiCnt_r == 16'(3 * divisorNow[9:4]))
        else $error("pulse width");
    a_div_legal: assert property (divisorNow inside {10'h300, 10'h180, 10'h0c0, 10'h080, 10'h040})
        else $error("bad divisor");
    a_hw_rate: assert property ((running && $stable(baud_select_pins) && baud_select_pins < 3'h5) [*5]
        |-> divisorNow == (baud_select_pins == 3'h3 ? 10'h080 : baud_select_pins == 3'h4 ? 10'h040
        : 10'h300 >> baud_select_pins)) else $error("pin rate");
    a_echo_bit: assert property (running && !modePin && !$past(modePin, 4) && $fell(uartIn) |-> ##[1:8] !uartOut)
        else $error("echo lag");
    a_cmd_no_ir: assert property ((!modePin) [*6] |-> !ir_pulse_out) else $error("ir in command");
    a_bit_hold: assert property (running && modePin && uartOut != lastOut_r |-> holdCnt_r >= 16'(divisorNow))
        else $error("bit too short");
    a_wake_wait: assert property ($rose(running) |-> enCnt_r >= 16'd1000) else $error("early wake");
    a_reset_hold: assert property ((!resetPinN) [*5] |-> !running) else $error("reset ignored");
    c_pulse: cover property ($fell(ir_pulse_out));
    c_fast: cover property (divisorNow == 10'h040);
    c_run: cover property ($rose(running));
endmodule : uic_codec_asserts

bind uic_codec uic_codec_asserts chk (.clk_sys, .sys_rst, .resetPinN, .enablePin, .modePin, .baud_select_pins,
    .uartIn, .uartOut, .ir_pulse_in, .ir_pulse_out, .running, .divisorNow);

// [uic_fifo.sv]
// Byte FIFO holding command-mode bytes awaiting baud decoding
`timescale 1ns/1ps
module uic_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) $error("uic_fifo: bad size");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr_r;
    logic [AW:0] rdPtr_r;
    wire full = (wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
    wire empty = wrPtr_r == rdPtr_r;
    assign inReady = !full;
    assign outValid = !empty;
    assign outData = mem[rdPtr_r[AW-1:0]];
    always_ff @(posedge clk_sys) begin
        if (inValid && !full) begin
            mem[wrPtr_r[AW-1:0]] <= inData;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
        end else begin
            if (inValid && !full) wrPtr_r <= wrPtr_r + 1'b1;
            if (outReady && !empty) rdPtr_r <= rdPtr_r + 1'b1;
        end
    end
endmodule : uic_fifo

// [uic_host_model.sv]
// Host UART and infrared pulse transmitter model
`timescale 1ns/1ps
module uic_host_model (
    input wire logic clk_sys,
    input wire logic rxLine,
    output logic txLine,
    output logic irLine
);
    int div = 768;
    initial begin
        txLine = 1'b1;
        irLine = 1'b1;
    end
    task automatic uartXfer(input logic [7:0] b, output logic [7:0] echo);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_sys) #1 txLine = f[i];
            repeat (div / 2) @(posedge clk_sys);
            #1 if (i > 0 && i < 9) echo[i-1] = rxLine;
            repeat (div - div / 2 - 1) @(posedge clk_sys);
        end
    endtask : uartXfer
    // Callers never overlap this with uartXfer: half duplex link
    task automatic irSend(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_sys) #1 irLine = f[i];
            repeat (3 * div / 16) @(posedge clk_sys);
            #1 irLine = 1'b1;
            repeat (div - 3 * div / 16 - 1) @(posedge clk_sys);
        end
    endtask : irSend
endmodule : uic_host_model

// [uic_pkg.sv]
// Package with constants and types for the infrared pulse codec
package uic_pkg;
    localparam int SUB_PER_BIT = 16;
    localparam logic [3:0] TX_PULSE_START = 4'h7;
    localparam logic [3:0] TX_PULSE_END = 4'ha;
    localparam logic [3:0] SUB_LAST = 4'hf;
    localparam logic [3:0] SUB_MID = 4'h7;
    localparam logic [3:0] FRAME_BITS = 4'ha;
    localparam logic [2:0] BAUD_SOFT_SEL = 3'h7;
    localparam logic [7:0] CMD_CHANGE = 8'h11;
    localparam logic [7:0] CODE_768 = 8'h87;
    localparam logic [7:0] CODE_384 = 8'h8b;
    localparam logic [7:0] CODE_192 = 8'h85;
    localparam logic [7:0] CODE_128 = 8'h83;
    localparam logic [7:0] CODE_64 = 8'h81;
    localparam logic [9:0] DIV_768 = 10'h300;
    localparam logic [9:0] DIV_384 = 10'h180;
    localparam logic [9:0] DIV_192 = 10'h0c0;
    localparam logic [9:0] DIV_128 = 10'h080;
    localparam logic [9:0] DIV_64 = 10'h040;
    localparam int WAKE_TOSC = 1000;
    localparam logic [10:0] WAKE_CYCLES = 11'(WAKE_TOSC);
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_WIDTH = 8;

    typedef enum logic [1:0] {
        UIC_ST_RESET = 2'b00,
        UIC_ST_WAKE = 2'b01,
        UIC_ST_RUN = 2'b10,
        UIC_ST_OFF = 2'b11
    } uic_state_t;

    typedef struct packed {
        logic enable;
        logic cmdMode;
        logic [2:0] baudSel;
    } uic_ctrl_t;
endpackage : uic_pkg
